/* File: ssl_pkg.sv */
// constants shared by both ends of the serial segment latch link
// assumes a single 250 MHz core clock at each end and a host-made serial clock
package ssl_pkg;

   // ==========================================
   // frame layout
   localparam int unsigned FRAME_BITS = 36;
   localparam int unsigned DATA_BITS = 35;
   localparam int unsigned SEG_COUNT = 23;
   localparam int unsigned START_VALUE = 1;

   // data bit number (1 = first bit after start) feeding each output, output 1 first
   localparam int unsigned SEG_MAP [SEG_COUNT] = '{
      2, 3, 4, 5, 6, 7, 8,
      12, 13, 14, 15,
      20, 21, 22, 23, 24, 25,
      27,
      30, 31, 32, 33, 34
   };

   // ==========================================
   // timing
   localparam int unsigned REF_CLK_PERIOD_PS = 4000;
   localparam int unsigned SER_CLK_MAX_KHZ = 500;
   localparam int unsigned SER_CLK_MIN_PERIOD_PS = 1000000000 / SER_CLK_MAX_KHZ;
   // half period of the serial clock, rounded up so the rate never exceeds the limit
   localparam int unsigned SER_HALF_CYC =
      (SER_CLK_MIN_PERIOD_PS / 2 + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;

   // ==========================================
   // buffering
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned SYNC_STAGES = 3;

   // ==========================================
   // host sequencer states
   typedef enum logic [1:0] {
      SSL_HS_IDLE = 2'b00,
      SSL_HS_LOW = 2'b01,
      SSL_HS_HIGH = 2'b10
   } ssl_host_state_t;

endpackage

/* File: ssl_link_if.sv */
// two-wire link: serial data and serial clock, no load strobe
// assumes the host end drives both wires and the device end only listens
`timescale 1ns/1ps
interface ssl_link_if;
   logic ser_data;
   logic ser_clk;

   modport host (
      output ser_data,
      output ser_clk
   );

   modport device (
      input ser_data,
      input ser_clk
   );
endinterface

/* File: ssl_device.sv */
// device end: serial shift register, 36th-clock latch transfer, static segment outputs
// assumes the serial wires come from another clock domain and are resynchronised here
`timescale 1ns/1ps
module ssl_device #(
   parameter int unsigned SEGS = ssl_pkg::SEG_COUNT,
   parameter int unsigned CNT_W = 16
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // serial link
   ssl_link_if.device link,
   // segment drive, one = sink on
   output logic [SEGS-1:0] seg_sink_out,
   // all 35 latched positions, for observation
   output logic [ssl_pkg::DATA_BITS-1:0] latch_bits_out,
   // status
   output logic load_pulse_out,
   output logic clear_pulse_out,
   output logic frame_pending_out,
   output logic [CNT_W-1:0] frame_count_out
);

   localparam int unsigned FB = ssl_pkg::FRAME_BITS;
   localparam int unsigned DB = ssl_pkg::DATA_BITS;
   localparam int unsigned NS = ssl_pkg::SYNC_STAGES;

   // ==========================================
   // input synchronisers
   logic [NS-1:0] clk_sync_q;
   logic [NS-1:0] dat_sync_q;
   logic clk_lvl_q;
   logic dat_lvl_q;
   logic clk_agree;
   logic dat_agree;
   logic ser_rise;
   logic ser_fall;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         clk_sync_q <= '0;
         dat_sync_q <= '0;
      end else begin
         clk_sync_q <= {clk_sync_q[NS-2:0], link.ser_clk};
         dat_sync_q <= {dat_sync_q[NS-2:0], link.ser_data};
      end
   end

   // a change counts only once the second and third stages agree
   assign clk_agree = (clk_sync_q[1] == clk_sync_q[2]);
   assign dat_agree = (dat_sync_q[1] == dat_sync_q[2]);

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         clk_lvl_q <= 1'b0;
         dat_lvl_q <= 1'b0;
      end else begin
         if (clk_agree) begin
            clk_lvl_q <= clk_sync_q[2];
         end
         if (dat_agree) begin
            dat_lvl_q <= dat_sync_q[2];
         end
      end
   end

   assign ser_rise = clk_agree && clk_sync_q[2] && !clk_lvl_q;
   assign ser_fall = clk_agree && !clk_sync_q[2] && clk_lvl_q;

   // data is taken from the agreed level, or the fresh agreed value if it moves together
   logic ser_bit;
   assign ser_bit = dat_agree ? dat_sync_q[2] : dat_lvl_q;

   // ==========================================
   // shift register and transfer control
   // stage FB-1 holds the start bit once 36 rising edges have passed
   logic [FB-1:0] shift_q;
   logic loaded_q;
   logic load_now;
   logic clear_now;

   // transfer while the serial clock is still high after the 36th rise
   assign load_now = shift_q[FB-1] && !loaded_q && clk_lvl_q;
   // clear on the low phase that follows, and only after a transfer
   assign clear_now = loaded_q && ser_fall;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         shift_q <= '0;
      end else if (ser_rise) begin
         shift_q <= {shift_q[FB-2:0], ser_bit};
      end else if (clear_now) begin
         // the next bit is sampled on the coming rise, so a start bit that
         // follows directly is not lost to this clear
         shift_q <= '0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         loaded_q <= 1'b0;
      end else if (load_now) begin
         loaded_q <= 1'b1;
      end else if (clear_now) begin
         loaded_q <= 1'b0;
      end
   end

   // ==========================================
   // output latches
   // latch index k-1 holds data bit k; data bit k sits at shift stage FB-1-k
   logic [DB-1:0] latch_q;
   logic [DB-1:0] latch_d;

   always_comb begin
      for (int k = 0; k < DB; k++) begin
         latch_d[k] = shift_q[DB-1-k];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         latch_q <= '0;
      end else if (load_now) begin
         latch_q <= latch_d;
      end
   end

   assign latch_bits_out = latch_q;

   // ==========================================
   // segment outputs
   // unused positions are simply never routed, whatever the host sends there
   logic [SEGS-1:0] seg_q;

   genvar g;
   generate
      for (g = 0; g < SEGS; g++) begin : g_seg
         always_ff @(posedge ref_clk_in) begin
            if (rst_in) begin
               seg_q[g] <= 1'b0;
            end else if (load_now) begin
               seg_q[g] <= latch_d[ssl_pkg::SEG_MAP[g] - 1];
            end
         end
      end
   endgenerate

   // a one turns the sink on; level holds until the next transfer
   assign seg_sink_out = seg_q;

   // ==========================================
   // status
   logic load_pulse_q;
   logic clear_pulse_q;
   logic [CNT_W-1:0] frame_count_q;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         load_pulse_q <= 1'b0;
         clear_pulse_q <= 1'b0;
      end else begin
         load_pulse_q <= load_now;
         clear_pulse_q <= clear_now;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         frame_count_q <= '0;
      end else if (load_now) begin
         frame_count_q <= frame_count_q + 1'b1;
      end
   end

   assign load_pulse_out = load_pulse_q;
   assign clear_pulse_out = clear_pulse_q;
   assign frame_pending_out = loaded_q;
   assign frame_count_out = frame_count_q;

endmodule

/* File: ssl_host.sv */
// host end: frame FIFO and two-wire serialiser with divided serial clock
// assumes a 250 MHz core clock; the serial clock is made here by a divider
`timescale 1ns/1ps

// ==========================================
// synchronous FIFO, first word fall-through
module ssl_fifo #(
   parameter int unsigned WIDTH = ssl_pkg::DATA_BITS,
   parameter int unsigned DEPTH = ssl_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // fill side
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   // drain side
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in,
   output logic [$clog2(DEPTH+1)-1:0] level_out
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned LW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [LW-1:0] level_q;
   logic push;
   logic pop;

   assign wr_ready_out = (level_q != LW'(DEPTH));
   assign rd_valid_out = (level_q != '0);
   assign push = wr_valid_in && wr_ready_out;
   assign pop = rd_valid_out && rd_ready_in;
   assign rd_data_out = mem_q[rd_ptr_q];
   assign level_out = level_q;

   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem_q[wr_ptr_q] <= wr_data_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         level_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            level_q <= level_q + 1'b1;
         end else if (pop && !push) begin
            level_q <= level_q - 1'b1;
         end
      end
   end
endmodule

// ==========================================
// serialiser
module ssl_host #(
   parameter int unsigned DEPTH = ssl_pkg::FIFO_DEPTH,
   parameter int unsigned HALF_CYC = ssl_pkg::SER_HALF_CYC
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // frame input, bit 0 is the first data bit after the start bit
   input wire logic [ssl_pkg::DATA_BITS-1:0] frame_data_in,
   input wire logic frame_valid_in,
   output logic frame_ready_out,
   // status
   output logic busy_out,
   // serial link
   ssl_link_if.host link
);
   localparam int unsigned FB = ssl_pkg::FRAME_BITS;
   localparam int unsigned DB = ssl_pkg::DATA_BITS;
   localparam int unsigned HW = $clog2(HALF_CYC + 1);

   logic [DB-1:0] fifo_data;
   logic fifo_valid;
   logic fifo_pop;

   ssl_fifo #(.WIDTH(DB), .DEPTH(DEPTH)) u_fifo (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .wr_data_in(frame_data_in),
      .wr_valid_in(frame_valid_in),
      .wr_ready_out(frame_ready_out),
      .rd_data_out(fifo_data),
      .rd_valid_out(fifo_valid),
      .rd_ready_in(fifo_pop),
      .level_out()
   );

   ssl_pkg::ssl_host_state_t state_q;
   logic [FB-1:0] shift_q;
   logic [5:0] bits_left_q;
   logic [HW-1:0] div_q;
   logic tick;
   logic sclk_q;
   logic sdat_q;

   // the serialiser pulls a frame only when idle, so the FIFO backs up to the source
   assign fifo_pop = (state_q == ssl_pkg::SSL_HS_IDLE) && fifo_valid;
   // half-period enable; the rounded-up count keeps the rate at or below 0.5 MHz
   assign tick = (div_q == HW'(HALF_CYC - 1));

   always_ff @(posedge ref_clk_in) begin
      if (rst_in || state_q == ssl_pkg::SSL_HS_IDLE || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_q <= ssl_pkg::SSL_HS_IDLE;
         shift_q <= '0;
         bits_left_q <= '0;
      end else begin
         case (state_q)
            ssl_pkg::SSL_HS_IDLE: begin
               if (fifo_pop) begin
                  shift_q <= {fifo_data, 1'b1};
                  bits_left_q <= 6'(FB);
                  state_q <= ssl_pkg::SSL_HS_LOW;
               end
            end
            ssl_pkg::SSL_HS_LOW: begin
               if (tick) begin
                  state_q <= ssl_pkg::SSL_HS_HIGH;
               end
            end
            ssl_pkg::SSL_HS_HIGH: begin
               if (tick) begin
                  shift_q <= {1'b0, shift_q[FB-1:1]};
                  bits_left_q <= bits_left_q - 1'b1;
                  state_q <= (bits_left_q == 6'h01) ? ssl_pkg::SSL_HS_IDLE
                                                     : ssl_pkg::SSL_HS_LOW;
               end
            end
            default: begin
               state_q <= ssl_pkg::SSL_HS_IDLE;
            end
         endcase
      end
   end

   // data changes only while the serial clock is low
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sclk_q <= 1'b0;
         sdat_q <= 1'b0;
      end else begin
         sclk_q <= (state_q == ssl_pkg::SSL_HS_HIGH) && !tick;
         if (state_q == ssl_pkg::SSL_HS_LOW) begin
            sdat_q <= shift_q[0];
         end else if (state_q == ssl_pkg::SSL_HS_IDLE) begin
            sdat_q <= 1'b0;
         end
      end
   end

   assign link.ser_clk = sclk_q;
   assign link.ser_data = sdat_q;
   assign busy_out = (state_q != ssl_pkg::SSL_HS_IDLE);
endmodule

/* File: ssl_link_monitor.sv */
// checker for the two-wire segment link and the device status outputs
// assumes the serial clock is a register of the same core clock domain
`timescale 1ns/1ps
module ssl_link_monitor #(
   // serial half period in core cycles, as set in the host
   parameter int unsigned HALF = ssl_pkg::SER_HALF_CYC
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // link wires
   input wire logic ser_data,
   input wire logic ser_clk,
   // device outputs
   input wire logic [22:0] seg_sink_out,
   input wire logic [34:0] latch_bits_out,
   input wire logic load_pulse_out,
   input wire logic clear_pulse_out,
   input wire logic frame_pending_out
);
   // rise to rise spacing may not drop below two half periods
   localparam int unsigned PER_MIN = 2 * HALF;
   // clear comes within the rest of the high phase plus synchroniser lag
   localparam int CLR_MAX = HALF + 12;
   logic clk_q;
   logic [5:0] rise_cnt_q;
   logic [9:0] per_cnt_q;
   logic [22:0] mapped;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   always_ff @(posedge ref_clk_in) begin
      clk_q <= rst_in ? 1'b0 : ser_clk;
   end
   // ==========================================
   // serial clock rises seen in the current frame
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rise_cnt_q <= 6'h00;
      end else if (ser_clk && !clk_q) begin
         rise_cnt_q <= (rise_cnt_q == 6'h23) ? 6'h00 : rise_cnt_q + 6'h01;
      end
   end
   // core cycles since the last serial clock rise, saturating
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         per_cnt_q <= 10'h3ff;
      end else if (ser_clk && !clk_q) begin
         per_cnt_q <= 10'h001;
      end else if (per_cnt_q != 10'h3ff) begin
         per_cnt_q <= per_cnt_q + 10'h001;
      end
   end
   always_comb begin
      for (int j = 0; j < 23; j++) begin
         mapped[j] = latch_bits_out[ssl_pkg::SEG_MAP[j]-1];
      end
   end
   sequence s_rise;
      ser_clk && !clk_q;
   endsequence
   sequence s_load_clear;
      frame_pending_out ##[1:CLR_MAX] clear_pulse_out;
   endsequence
   // ==========================================
   chk_start_bit_one: assert property (ser_clk && !clk_q && rise_cnt_q == 6'h00 |-> ser_data)
      else $error("start bit not one");
   chk_load_on_last: assert property (ser_clk && !clk_q && rise_cnt_q == 6'h23 |-> ##[1:12] load_pulse_out)
      else $error("no transfer after 36th clock");
   chk_load_full_frame: assert property (load_pulse_out |-> rise_cnt_q == 6'h00)
      else $error("transfer inside a frame");
   chk_load_then_clear: assert property (load_pulse_out |-> s_load_clear)
      else $error("no clear after transfer");
   chk_clear_full_frame: assert property (clear_pulse_out |-> rise_cnt_q == 6'h00 && !frame_pending_out)
      else $error("clear without full frame");
   chk_latch_static: assert property ($changed(latch_bits_out) |-> frame_pending_out)
      else $error("latches changed outside transfer");
   chk_seg_static: assert property ($changed(seg_sink_out) |-> frame_pending_out)
      else $error("outputs changed outside transfer");
   chk_seg_mapping: assert property (load_pulse_out |=> seg_sink_out == mapped)
      else $error("output mapping wrong");
   chk_data_held_high: assert property (ser_clk && clk_q |-> $stable(ser_data))
      else $error("data moved while clock high");
   chk_half_period: assert property (s_rise |-> per_cnt_q >= 10'(PER_MIN))
      else $error("serial clock faster than limit");
   chk_reset_clears: assert property (disable iff (1'b0) rst_in |=> seg_sink_out == 23'h0 && latch_bits_out == 35'h0)
      else $error("reset left state");
endmodule

/* File: serial_segment_latch_driver_tb.sv */
// bench: host and device joined by the link, frames pushed through the host FIFO
// assumes a 4 ns core clock and a shortened serial half period of 8 cycles
`timescale 1ns/1ps
module serial_segment_latch_driver_tb;
   typedef struct packed {
      logic [34:0] frame;
      logic [22:0] segs;
   } ssl_row_t;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [34:0] frame_data_in = 35'h0;
   logic frame_valid_in = 1'b0;
   logic frame_ready_out, busy_out, load_pulse_out, clear_pulse_out, frame_pending_out;
   logic [22:0] seg_sink_out;
   logic [34:0] latch_bits_out;
   logic [15:0] frame_count_out;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;
   logic seg_due = 1'b0;
   ssl_row_t cur;
   ssl_row_t exp_q[$];
   ssl_row_t rows [10] = '{
      '{35'h7_ffff_ffff, 23'h7f_ffff}, '{35'h0_0000_0000, 23'h00_0000},
      '{35'h0_0000_0001, 23'h00_0000}, '{35'h0_0000_00fe, 23'h00_007f},
      '{35'h0_0000_0800, 23'h00_0080}, '{35'h0_0007_8700, 23'h00_0000},
      '{35'h0_01f8_0000, 23'h01_f800}, '{35'h0_0400_0000, 23'h02_0000},
      '{35'h3_e000_0000, 23'h7c_0000}, '{35'h4_1a00_0000, 23'h00_0000}};

   ssl_link_if link();
   ssl_host #(.HALF_CYC(8)) ssl_host_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .frame_data_in(frame_data_in), .frame_valid_in(frame_valid_in),
      .frame_ready_out(frame_ready_out), .busy_out(busy_out), .link(link));
   ssl_device ssl_device_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link),
      .seg_sink_out(seg_sink_out), .latch_bits_out(latch_bits_out),
      .load_pulse_out(load_pulse_out), .clear_pulse_out(clear_pulse_out),
      .frame_pending_out(frame_pending_out), .frame_count_out(frame_count_out));
   ssl_link_monitor #(.HALF(8)) ssl_link_monitor_i (.ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .ser_data(link.ser_data), .ser_clk(link.ser_clk), .seg_sink_out(seg_sink_out),
      .latch_bits_out(latch_bits_out), .load_pulse_out(load_pulse_out),
      .clear_pulse_out(clear_pulse_out), .frame_pending_out(frame_pending_out));

   initial begin
      forever #2 ref_clk_in = ~ref_clk_in;
   end
   // ==========================================
   // shared tasks
   task automatic check(input logic [34:0] got, input logic [34:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      if (mismatches == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // leaves valid high so back-to-back words never see a second assignment
   task automatic push(input logic [34:0] f, input logic [22:0] s);
      frame_data_in <= f;
      frame_valid_in <= 1'b1;
      @(negedge ref_clk_in);
      while (frame_ready_out !== 1'b1) @(negedge ref_clk_in);
      @(posedge ref_clk_in);
      exp_q.push_back('{f, s});
   endtask
   // returns on a rising edge so the next request starts there
   task automatic drain(input int limit);
      frame_valid_in <= 1'b0;
      repeat (limit) begin
         @(negedge ref_clk_in);
         if (exp_q.size() == 0 && !seg_due) begin
            @(posedge ref_clk_in);
            return;
         end
      end
      check(35'h1, 35'h0);
      @(posedge ref_clk_in);
   endtask
   function automatic logic [22:0] map_segs(input logic [34:0] f);
      for (int j = 0; j < 23; j++) map_segs[j] = f[ssl_pkg::SEG_MAP[j]-1];
   endfunction
   // ==========================================
   // every transfer is matched against the next expected word
   always @(negedge ref_clk_in) begin
      if (seg_due) begin
         check(35'(seg_sink_out), 35'(cur.segs));
         seg_due = 1'b0;
      end
      if (load_pulse_out === 1'b1 && !rst_in) begin
         if (exp_q.size() == 0) begin
            check(35'h1, 35'h0);
         end else begin
            cur = exp_q.pop_front();
            check(latch_bits_out, cur.frame);
            seg_due = 1'b1;
         end
      end
   end
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         give_verdict();
      end
   end
   // ==========================================
   initial begin
      repeat (20) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(negedge ref_clk_in);
      check({latch_bits_out[34:2], link.ser_clk, link.ser_data}, 35'h0);
      check(35'({seg_sink_out, frame_ready_out, busy_out}), 35'h2);
      @(posedge ref_clk_in);
      foreach (rows[i]) begin
         push(rows[i].frame, rows[i].segs);
         drain(2000);
      end
      // back-to-back frames: 17 words fill the serialiser and all 16 FIFO places
      for (int i = 0; i < 18; i++) begin
         push(~(35'h1 << i), map_segs(~(35'h1 << i)));
         if (i == 16) begin
            @(negedge ref_clk_in);
            check(35'(frame_ready_out), 35'h0);
            @(posedge ref_clk_in);
         end
      end
      drain(20000);
      check(35'(frame_count_out), 35'h1c);
      // reset in mid-frame, then a whole frame must still arrive intact
      @(posedge ref_clk_in);
      push(35'h7_ffff_ffff, 23'h7f_ffff);
      frame_valid_in <= 1'b0;
      repeat (200) @(posedge ref_clk_in);
      check(35'(busy_out), 35'h1);
      rst_in <= 1'b1;
      exp_q.delete();
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(negedge ref_clk_in);
      check({seg_sink_out, 11'h0, busy_out}, 35'h0);
      check(latch_bits_out, 35'h0);
      @(posedge ref_clk_in);
      push(35'h0_0000_0002, 23'h00_0001);
      drain(2000);
      give_verdict();
   end
endmodule
